// file: rtl/sac_pkg.sv
// Package with encodings and reset values for the accumulator subtract unit
package sac_pkg;
    // ------------------------------------------------------------
    // Instruction word layout
    // ------------------------------------------------------------
    localparam int          SAC_WORD_W   = 12;
    localparam int          SAC_OP_MSB   = 11;
    localparam int          SAC_OP_LSB   = 6;
    localparam logic [5:0]  SAC_OP_CODE  = 6'h02;
    localparam int          SAC_DEST_BIT = 5;
    localparam int          SAC_LOC_MSB  = 4;
    localparam int          SAC_LOC_LSB  = 0;
    localparam int          SAC_LOC_W    = 5;
    localparam logic        SAC_DEST_ACC = 1'h0;
    localparam logic        SAC_DEST_REG = 1'h1;
    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0]  SAC_DATA_RST = 8'h00;
    localparam logic [4:0]  SAC_LOC_RST  = 5'h00;
endpackage

// file: rtl/sac_minus_accum.sv
// Accumulator subtract unit: register minus accumulator with flags
`timescale 1ns/1ps
module sac_minus_accum
    import sac_pkg::*;
#(
    parameter int DATA_W = 8
) (
    // Clock and reset
    input  wire logic                  ref_clk,
    input  wire logic                  arst_n,
    // Instruction word to be decoded and operands
    input  wire logic                  instr_valid,
    input  wire logic [SAC_WORD_W-1:0] instr_word,
    input  wire logic [DATA_W-1:0]     accum_in,
    input  wire logic [DATA_W-1:0]     file_in,
    // Result and write targets
    output logic                       minus_accum_op,
    output logic [DATA_W-1:0]          result,
    output logic                       accum_we,
    output logic                       file_we,
    output logic [SAC_LOC_W-1:0]       file_loc,
    // Flags
    output logic                       flags_we,
    output logic                       carry,
    output logic                       nibble_borrow_n,
    output logic                       zero
);

    // ------------------------------------------------------------
    // Decode helper
    // ------------------------------------------------------------
    function automatic logic is_minus_accum(
        input logic [SAC_WORD_W-1:0] word
    );
        return (word[SAC_OP_MSB:SAC_OP_LSB] == SAC_OP_CODE);
    endfunction

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    logic              hit;
    logic              dest;
    logic [DATA_W:0]   sum;
    logic [4:0]        low_sum;

    assign hit  = instr_valid && is_minus_accum(instr_word);
    assign dest = instr_word[SAC_DEST_BIT];

    // ------------------------------------------------------------
    // Arithmetic
    // ------------------------------------------------------------
    assign sum     = {1'h0, file_in} + {1'h0, ~accum_in}
                   + {{DATA_W{1'h0}}, 1'h1};
    assign low_sum = {1'h0, file_in[3:0]} + {1'h0, ~accum_in[3:0]}
                   + 5'h01;

    // ------------------------------------------------------------
    // Result and write enables
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            minus_accum_op <= 1'h0;
            result         <= SAC_DATA_RST;
            accum_we       <= 1'h0;
            file_we        <= 1'h0;
            file_loc       <= SAC_LOC_RST;
        end else begin
            minus_accum_op <= hit;
            accum_we       <= hit && (dest == SAC_DEST_ACC);
            file_we        <= hit && (dest == SAC_DEST_REG);
            if (hit) begin
                result   <= sum[DATA_W-1:0];
                file_loc <= instr_word[SAC_LOC_MSB:SAC_LOC_LSB];
            end
        end
    end

    // ------------------------------------------------------------
    // Flags
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            flags_we        <= 1'h0;
            carry           <= 1'h0;
            nibble_borrow_n <= 1'h0;
            zero            <= 1'h0;
        end else begin
            flags_we <= hit;
            if (hit) begin
                carry           <= sum[DATA_W];
                nibble_borrow_n <= low_sum[4];
                zero            <= (sum[DATA_W-1:0] == '0);
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking chk_clk @(posedge ref_clk); endclocking
    default disable iff (!arst_n);

    a_carry_no_borrow: assert property (
        hit |=> (carry == ($past(file_in) >= $past(accum_in)))
    ) else $error("carry does not match borrow");
    a_result_value: assert property (
        hit |=> (result == DATA_W'($past(file_in) - $past(accum_in)))
    ) else $error("result is not register minus accumulator");
    a_dest_acc: assert property (
        (hit && !dest) |=> (accum_we && !file_we)
    ) else $error("accumulator destination wrong");
    a_dest_reg: assert property (
        (hit && dest) |=> (file_we && !accum_we)
    ) else $error("register destination wrong");
    a_zero_flag: assert property (
        flags_we |-> (zero == (result == '0))
    ) else $error("zero flag mismatch");
    a_nibble_flag: assert property (
        hit |=> (nibble_borrow_n ==
            ($past(file_in[3:0]) >= $past(accum_in[3:0])))
    ) else $error("nibble carry mismatch");
    a_flags_hold: assert property (
        !hit |=> ($stable(carry) && $stable(zero) && $stable(nibble_borrow_n))
    ) else $error("flags changed without operation");
    a_decode_only: assert property (
        (instr_valid && !is_minus_accum(instr_word)) |=> !minus_accum_op
    ) else $error("operation decoded from wrong word");

    // ------------------------------------------------------------
    // Checks on strobes and location
    // ------------------------------------------------------------
    a_hit_op_pulse: assert property (
        hit |=> minus_accum_op
    ) else $error("operation strobe missing");
    a_idle_no_op: assert property (
        !hit |=> !minus_accum_op
    ) else $error("operation strobe without operation");
    a_invalid_ignored: assert property (
        !instr_valid |=> (!minus_accum_op && !flags_we)
    ) else $error("invalid word acted upon");
    a_idle_no_write: assert property (
        !hit |=> (!accum_we && !file_we)
    ) else $error("write strobe without operation");
    a_one_target: assert property (
        minus_accum_op |-> (accum_we != file_we)
    ) else $error("not exactly one write target");
    a_we_with_op: assert property (
        (accum_we || file_we) |-> minus_accum_op
    ) else $error("write strobe outside operation");
    a_acc_dest_bit: assert property (
        accum_we |-> ($past(instr_word[SAC_DEST_BIT]) == SAC_DEST_ACC)
    ) else $error("accumulator written with wrong destination");
    a_reg_dest_bit: assert property (
        file_we |-> ($past(instr_word[SAC_DEST_BIT]) == SAC_DEST_REG)
    ) else $error("register written with wrong destination");
    a_loc_capture: assert property (
        hit |=> (file_loc == $past(instr_word[SAC_LOC_MSB:SAC_LOC_LSB]))
    ) else $error("location not captured");
    a_loc_hold: assert property (
        !hit |=> $stable(file_loc)
    ) else $error("location changed without operation");
    a_flags_we_op: assert property (
        flags_we |-> minus_accum_op
    ) else $error("flag strobe without operation");
    a_op_flags_we: assert property (
        minus_accum_op |-> flags_we
    ) else $error("operation without flag strobe");
    a_flags_we_src: assert property (
        flags_we |-> $past(hit)
    ) else $error("flag strobe without decoded word");

    // ------------------------------------------------------------
    // Checks on the result
    // ------------------------------------------------------------
    a_result_add_back: assert property (
        hit |=> (DATA_W'(result + $past(accum_in)) == $past(file_in))
    ) else $error("result plus accumulator is not register");
    a_result_hold: assert property (
        !hit |=> $stable(result)
    ) else $error("result changed without operation");
    a_borrow_wrap: assert property (
        (hit && (accum_in > file_in)) |=> (result > $past(file_in))
    ) else $error("borrow result did not wrap");
    a_no_borrow_fits: assert property (
        (hit && (accum_in <= file_in)) |=> (result <= $past(file_in))
    ) else $error("result exceeds register without borrow");
    a_zero_acc_same: assert property (
        (hit && (accum_in == '0)) |=> (result == $past(file_in))
    ) else $error("subtracting zero changed value");

    // ------------------------------------------------------------
    // Checks on the flags
    // ------------------------------------------------------------
    a_carry_set: assert property (
        (hit && (file_in >= accum_in)) |=> carry
    ) else $error("carry not set without borrow");
    a_carry_clear: assert property (
        (hit && (accum_in > file_in)) |=> !carry
    ) else $error("carry not cleared on borrow");
    a_zero_set: assert property (
        (hit && (file_in == accum_in)) |=> zero
    ) else $error("zero flag not set");
    a_zero_clear: assert property (
        (hit && (file_in != accum_in)) |=> !zero
    ) else $error("zero flag not cleared");
    a_nibble_clear: assert property (
        (hit && (accum_in[3:0] > file_in[3:0])) |=> !nibble_borrow_n
    ) else $error("nibble flag not cleared on borrow");
    a_nibble_set: assert property (
        (hit && (accum_in[3:0] <= file_in[3:0])) |=> nibble_borrow_n
    ) else $error("nibble flag not set without borrow");
    a_zero_carry: assert property (
        (flags_we && zero) |-> carry
    ) else $error("zero result with borrow");
    a_zero_nibble: assert property (
        (flags_we && zero) |-> nibble_borrow_n
    ) else $error("zero result with nibble borrow");

endmodule

// file: bench/sac_minus_accum_tb.sv
// Testbench for the accumulator subtract unit
`timescale 1ns/1ps
module sac_minus_accum_tb;
    import sac_pkg::*;
    logic        ref_clk     = 1'h0;
    logic        arst_n      = 1'h0;
    logic        instr_valid = 1'h0;
    logic [11:0] instr_word  = 12'h000;
    logic [7:0]  accum_in    = 8'h00;
    logic [7:0]  file_in     = 8'h00;
    logic [7:0]  result;
    logic [4:0]  file_loc;
    logic        minus_accum_op, accum_we, file_we, flags_we;
    logic        carry, nibble_borrow_n, zero;
    logic [15:0] lfsr        = 16'hD618;
    logic [19:0] exp_out     = 20'h00000;
    int          n_errors    = 0;
    int          n_tests     = 0;
    always #2.5 ref_clk = ~ref_clk;
    sac_minus_accum i_dut (.ref_clk(ref_clk), .arst_n(arst_n),
        .instr_valid(instr_valid), .instr_word(instr_word),
        .accum_in(accum_in), .file_in(file_in), .result(result),
        .minus_accum_op(minus_accum_op), .accum_we(accum_we),
        .file_we(file_we), .file_loc(file_loc), .flags_we(flags_we),
        .carry(carry), .nibble_borrow_n(nibble_borrow_n), .zero(zero));
    function automatic logic [15:0] step(logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // Strobes, flags, location and result after one edge
    function automatic logic [19:0] predict(logic v, logic [11:0] w,
            logic [7:0] f, logic [7:0] a, logic [19:0] prev);
        logic [8:0] d;
        d = {1'h0, f} - {1'h0, a};
        if (!(v && w[11:6] == SAC_OP_CODE))
            return {4'h0, prev[15:0]};
        return {1'h1, w[5] == SAC_DEST_ACC, w[5] == SAC_DEST_REG, 1'h1,
                !d[8], f[3:0] >= a[3:0], d[7:0] == 8'h00, w[4:0], d[7:0]};
    endfunction
    task automatic compare_out(logic [19:0] e);
        logic [19:0] got;
        got = {minus_accum_op, accum_we, file_we, flags_we, carry,
               nibble_borrow_n, zero, file_loc, result};
        n_tests++;
        if (got !== e) begin
            n_errors++;
            $display("ERROR outputs expected %h seen %h", e, got);
        end
    endtask
    task automatic run_op(logic v, logic [11:0] w, logic [7:0] f,
            logic [7:0] a);
        @(posedge ref_clk);
        instr_valid <= v;
        instr_word  <= w;
        file_in     <= f;
        accum_in    <= a;
        @(posedge ref_clk);
        #1;
        exp_out = predict(v, w, f, a, exp_out);
        compare_out(exp_out);
    endtask
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        #10000;
        n_errors++;
        complete_run;
    end
    initial begin
        logic [11:0] w;
        repeat (12) @(posedge ref_clk);
        arst_n <= 1'h1;
        compare_out(exp_out);
        run_op(1'h1, 12'h0A3, 8'h03, 8'h02);
        run_op(1'h1, 12'h09F, 8'h02, 8'h02);
        run_op(1'h1, 12'h083, 8'h01, 8'h02);
        run_op(1'h1, 12'h0C3, 8'h10, 8'h01);
        run_op(1'h1, 12'h09F, 8'h10, 8'h01);
        run_op(1'h1, 12'h083, 8'h55, 8'h11);
        run_op(1'h0, 12'h083, 8'h55, 8'h11);
        $display("test corner done");
        repeat (300) begin
            lfsr = step(lfsr);
            w = {lfsr[15] ? SAC_OP_CODE : lfsr[11:6], lfsr[5:0]};
            lfsr = step(lfsr);
            run_op(lfsr[15] | lfsr[14], w, lfsr[7:0], lfsr[15:8]);
        end
        $display("test random done");
        @(posedge ref_clk);
        instr_valid <= 1'h0;
        arst_n      <= 1'h0;
        @(posedge ref_clk);
        #1;
        exp_out = 20'h00000;
        compare_out(exp_out);
        @(posedge ref_clk);
        arst_n <= 1'h1;
        run_op(1'h1, 12'h0BF, 8'h80, 8'h7F);
        $display("test reset done");
        complete_run;
    end
endmodule
